/* hw/jts_sel_top.v */
// jtag tap select latch: routes test pins to boundary-scan or emulation tap
`timescale 1ns/1ps
`include "jts_sel_map.vh"
module jts_sel_top (
    // clock and reset
    input wire sys_clk,
    input wire resetn,
    input wire clk_en,
    // jtag pins
    input wire trst_pin,
    input wire tck_pin,
    input wire tms_pin,
    input wire tdi_pin,
    output reg tdo_out,
    output reg tdo_oe,
    // emulation select line, four signals
    input wire emulation_select_line_in,
    output reg emulation_select_line_out,
    output reg emulation_select_line_oe,
    output reg emulation_select_line_pull_en,
    // pull control
    input wire pull_inhibit_control_two,
    // boundary-scan tap side
    output reg bscan_tck,
    output reg bscan_tms,
    output reg bscan_tdi,
    output reg bscan_tck_rise,
    output reg bscan_tck_fall,
    input wire bscan_tdo,
    input wire bscan_tdo_en,
    // emulation tap side
    output reg emu_tck,
    output reg emu_tms,
    output reg emu_tdi,
    output reg emu_tck_rise,
    output reg emu_tck_fall,
    input wire emu_tdo,
    input wire emu_tdo_en,
    // emulation event line control
    input wire emu_evt_drive,
    input wire emu_evt_level,
    output reg emu_evt_in,
    // status
    output reg tap_sel,
    output reg test_mode
);
    // ****************
    // input synchronisers
    // ****************
    wire [4:0] pin_s;
    jts_sync2 #(.W(5)) u_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .d({emulation_select_line_in, tdi_pin, tms_pin, tck_pin, trst_pin}),
        .q(pin_s)
    );
    wire trst_s = pin_s[0];
    wire tck_s = pin_s[1];
    wire tms_s = pin_s[2];
    wire tdi_s = pin_s[3];
    wire sel_s = pin_s[4];

    // ****************
    // state codes and decode helper
    // ****************
    localparam [`JTS_ST_W-1:0] ST_FUNC = `JTS_ST_FUNC;
    localparam [`JTS_ST_W-1:0] ST_TEST = `JTS_ST_TEST;

    // true while test is active and the latched choice is the wanted tap
    function tap_pick;
        input active_in;
        input sel_in;
        input want;
        begin
            tap_pick = active_in && (sel_in == want);
        end
    endfunction

    reg [`JTS_ST_W-1:0] st_r;
    reg [`JTS_ST_W-1:0] st_nxt;
    reg sel_r;
    reg sel_nxt;
    reg tck_d_r;
    wire tck_rise = tck_s & ~tck_d_r;
    wire tck_fall = ~tck_s & tck_d_r;

    // ****************
    // state machine
    // ****************
    always @* begin
        st_nxt = st_r;
        sel_nxt = sel_r;
        case (st_r)
            ST_FUNC: begin
                if (trst_s) begin
                    // selection latched on the low-to-high reset edge only
                    sel_nxt = sel_s; // R1
                    st_nxt = ST_TEST;
                end
            end
            ST_TEST: begin
                if (!trst_s) begin
                    st_nxt = ST_FUNC; // R7
                end
            end
            default: begin
                st_nxt = ST_FUNC;
            end
        endcase
    end

    wire active = (st_r == ST_TEST) && trst_s;
    wire use_emu = tap_pick(active, sel_r, `JTS_SEL_EMU);
    wire use_bs = tap_pick(active, sel_r, `JTS_SEL_BSCAN);

    // ****************
    // state, latched choice and status
    // ****************
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= ST_FUNC;
            sel_r <= `JTS_SEL_RST;
            tck_d_r <= 1'b0;
            tap_sel <= `JTS_SEL_RST;
            test_mode <= 1'b0;
        end else if (clk_en) begin
            st_r <= st_nxt;
            sel_r <= sel_nxt;
            tck_d_r <= tck_s;
            // status lags the latch, so it never shows a half-taken choice
            tap_sel <= sel_r; // R1
            test_mode <= active; // R7
        end
    end

    // ****************
    // pull-up control
    // ****************
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            emulation_select_line_pull_en <= `JTS_PULL_EN_RST;
        end else if (clk_en) begin
            // pull-up inhibit: high disables the pull-up
            emulation_select_line_pull_en <= ~pull_inhibit_control_two; // R6
        end
    end

    // ****************
    // boundary-scan tap routing
    // ****************
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            bscan_tck <= 1'b0;
            bscan_tms <= 1'b1;
            bscan_tdi <= 1'b1;
            bscan_tck_rise <= 1'b0;
            bscan_tck_fall <= 1'b0;
        end else if (clk_en) begin
            // idle levels keep an unselected tap parked in its reset state
            bscan_tck <= use_bs & tck_s; // R2
            bscan_tms <= use_bs ? tms_s : 1'b1; // R2
            bscan_tdi <= use_bs ? tdi_s : 1'b1; // R2
            bscan_tck_rise <= use_bs & tck_rise; // R8
            bscan_tck_fall <= use_bs & tck_fall; // R8
        end
    end

    // ****************
    // emulation tap routing
    // ****************
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            emu_tck <= 1'b0;
            emu_tms <= 1'b1;
            emu_tdi <= 1'b1;
            emu_tck_rise <= 1'b0;
            emu_tck_fall <= 1'b0;
        end else if (clk_en) begin
            emu_tck <= use_emu & tck_s; // R3
            emu_tms <= use_emu ? tms_s : 1'b1; // R3
            emu_tdi <= use_emu ? tdi_s : 1'b1; // R3
            emu_tck_rise <= use_emu & tck_rise; // R8
            emu_tck_fall <= use_emu & tck_fall; // R8
        end
    end

    // ****************
    // test data out
    // ****************
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tdo_out <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (clk_en) begin
            // data out only moves on the falling test clock edge
            if (!active) begin
                tdo_oe <= 1'b0; // R7
            end else if (tck_fall) begin
                if (use_emu) begin
                    tdo_out <= emu_tdo; // R8
                    tdo_oe <= emu_tdo_en; // R3
                end else begin
                    tdo_out <= bscan_tdo; // R8
                    tdo_oe <= bscan_tdo_en; // R2
                end
            end
        end
    end

    // ****************
    // emulation event line
    // ****************
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            emulation_select_line_out <= 1'b0;
            emulation_select_line_oe <= 1'b0;
            emu_evt_in <= 1'b0;
        end else if (clk_en) begin
            // event line: never driven while it still acts as a selector
            emulation_select_line_oe <= active & emu_evt_drive; // R5
            emulation_select_line_out <= active & emu_evt_level; // R4
            emu_evt_in <= active & ~emu_evt_drive & sel_s; // R4
        end
    end
endmodule

/* hw/jts_sel_map.vh */
// constants for the jtag tap select latch
// Function
// R1: on the rise of test reset after a low period, the level on the select line is latched as the port choice.
// R2: a latched choice of 0 routes clock, mode, data in and data out to the boundary-scan port.
// R3: a latched choice of 1 routes the four jtag pins to the emulation port instead.
// R4: once test reset is high the select line stops selecting and carries events both ways.
// R5: emulation logic decides whether the select line is driven or sampled as an event line.
// R6: a control setting enables or disables the internal pull-up on the select line.
// R7: while test reset is low the jtag pins are ignored and the device stays in functional mode.
// R8: the selected port samples mode and data in on the test clock rise and changes data out on its fall.
`ifndef JTS_SEL_MAP_VH
`define JTS_SEL_MAP_VH
// ****************
// selection codes
// ****************
`define JTS_SEL_BSCAN 1'h0
`define JTS_SEL_EMU 1'h1
// ****************
// reset values
// ****************
`define JTS_SEL_RST 1'h1
`define JTS_PULL_EN_RST 1'h1
// ****************
// states
// ****************
`define JTS_ST_FUNC 2'h0
`define JTS_ST_TEST 2'h1
`define JTS_ST_W 2
`endif

/* hw/jts_sync2.v */
// two flip-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module jts_sync2 #(
    parameter W = 4
) (
    // clock and reset
    input wire sys_clk,
    input wire resetn,
    input wire clk_en,
    // data
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_r;
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= {W{1'b0}};
            q <= {W{1'b0}};
        end else if (clk_en) begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

/* verif/jts_sel_properties.sv */
// assertions on the ports of the jtag tap select latch
`timescale 1ns/1ps
module jts_sel_properties (
    // watched ports
    input wire sys_clk, resetn, tms_pin, pull_inhibit_control_two, emu_evt_drive, emu_evt_level,
    input wire tdo_oe, emulation_select_line_out, emulation_select_line_oe,
    input wire emulation_select_line_pull_en, bscan_tms, emu_tms, emu_tck, tap_sel, test_mode
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    pull_follow_a: assert property ($stable(pull_inhibit_control_two) [*3] |->
        emulation_select_line_pull_en == !pull_inhibit_control_two) else $error("pull wrong");
    refuse_out_a: assert property (!test_mode && !$past(test_mode) |->
        !tdo_oe && !emulation_select_line_oe) else $error("drives out of test");
    idle_tap_a: assert property (!test_mode && !$past(test_mode, 3) |->
        !emu_tck && emu_tms && bscan_tms) else $error("tap not idle");
    sel_hold_a: assert property (test_mode && $past(test_mode) |-> $stable(tap_sel))
        else $error("choice moved");
    bscan_route_a: assert property ($stable(tms_pin) [*5] && test_mode && !tap_sel
        && $past(test_mode, 4) |-> bscan_tms == tms_pin && emu_tms) else $error("bscan route");
    emu_route_a: assert property ($stable(tms_pin) [*5] && test_mode && tap_sel
        && $past(test_mode, 4) |-> emu_tms == tms_pin && bscan_tms) else $error("emu route");
    event_dir_a: assert property ($rose(emulation_select_line_oe) |-> test_mode)
        else $error("event line driven out of test");
    event_drive_a: assert property ($stable({emu_evt_drive, emu_evt_level}) [*3] &&
        test_mode && $past(test_mode, 3) |-> emulation_select_line_oe == emu_evt_drive &&
        (!emu_evt_drive || emulation_select_line_out == emu_evt_level)) else $error("event");
endmodule
bind jts_sel_top jts_sel_properties chk (.*);

/* verif/jts_emu_model.sv */
// emulator model driving the test pins and the select line
`timescale 1ns/1ps
module jts_emu_model (
    // clock
    input wire sys_clk
);
    reg trst = 0, tck = 0, tms = 1, tdi = 1, sel_en = 1, sel_v = 1;
    task tick(input integer n);
        repeat (n) @(posedge sys_clk);
    endtask
    // ****
    // attach: select held well around the trst rise, sync lag included
    // ****
    task attach(input reg s);
        trst <= 0; sel_en <= 1; sel_v <= s; tick(4);
        trst <= 1; tick(4);
        sel_en <= 0;
    endtask
    task shift(input reg m, input reg d);
        tck <= 1; tick(8);
        tck <= 0; tms <= m; tdi <= d; tick(8);
    endtask
endmodule

/* verif/jts_sel_top_bench.sv */
// self-checking bench for the jtag tap select latch
`timescale 1ns/1ps
module jts_sel_top_bench;
    reg sys_clk = 0, resetn = 0, inhibit = 0, tdo_b = 0, tdo_e = 0, drv = 0, lvl = 0;
    wire tdo_out, tdo_oe, sl_out, sl_oe, pull_en, b_tms, b_tdi, e_tms, e_tdi, evt_in;
    wire tap_sel, test_mode;
    wire b_tck, b_rise, b_fall, e_tck, e_rise, e_fall;
    reg ce = 1, ten_b = 0, ten_e = 0;
    reg [1:0] tck_q = 2'h0;
    integer n_errors = 0, cmp_count = 0, i, s;
    integer n_br = 0, n_bf = 0, n_bt = 0, n_er = 0, n_ef = 0, n_et = 0;
    reg [31:0] rnd = 32'h67ea;
    jts_emu_model pm (.sys_clk(sys_clk));
    // released line floats high through the pull-up
    wire esl = sl_oe ? sl_out : (pm.sel_en ? pm.sel_v : 1'h1);
    jts_sel_top dut (.sys_clk(sys_clk), .resetn(resetn), .clk_en(ce), .trst_pin(pm.trst),
        .tck_pin(pm.tck), .tms_pin(pm.tms), .tdi_pin(pm.tdi), .tdo_out(tdo_out), .tdo_oe(tdo_oe),
        .emulation_select_line_in(esl), .emulation_select_line_out(sl_out),
        .emulation_select_line_oe(sl_oe), .emulation_select_line_pull_en(pull_en),
        .pull_inhibit_control_two(inhibit), .bscan_tck(b_tck), .bscan_tms(b_tms),
        .bscan_tdi(b_tdi), .bscan_tck_rise(b_rise), .bscan_tck_fall(b_fall),
        .bscan_tdo(tdo_b), .bscan_tdo_en(ten_b), .emu_tck(e_tck), .emu_tms(e_tms),
        .emu_tdi(e_tdi), .emu_tck_rise(e_rise), .emu_tck_fall(e_fall),
        .emu_tdo(tdo_e), .emu_tdo_en(ten_e), .emu_evt_drive(drv), .emu_evt_level(lvl),
        .emu_evt_in(evt_in), .tap_sel(tap_sel), .test_mode(test_mode));
    function [31:0] lfsr(input [31:0] v);
        lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task chk(input reg got, input reg exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("wrong value at %0t: got %b exp %b", $time, got, exp);
        end
    endtask
    task report_and_stop;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial forever #12.5 sys_clk = ~sys_clk;
    // edge counts of the routed tap clocks and strobes, checked per choice
    always @(posedge sys_clk) begin
        tck_q <= {e_tck, b_tck};
        if (resetn) begin
            n_bt <= n_bt + ((b_tck === 1'b1 && tck_q[0] === 1'b0) ? 1 : 0);
            n_et <= n_et + ((e_tck === 1'b1 && tck_q[1] === 1'b0) ? 1 : 0);
            n_br <= n_br + ((b_rise === 1'b1) ? 1 : 0);
            n_bf <= n_bf + ((b_fall === 1'b1) ? 1 : 0);
            n_er <= n_er + ((e_rise === 1'b1) ? 1 : 0);
            n_ef <= n_ef + ((e_fall === 1'b1) ? 1 : 0);
        end
    end
    // generous: the sequence needs a few hundred cycles
    initial begin
        #2000000;
        n_errors = n_errors + 1;
        report_and_stop;
    end
    // ****
    // both choices, routing, event line, leaving test
    // ****
    initial begin
        repeat (20) @(posedge sys_clk);
        resetn <= 1;
        for (s = 0; s < 2; s = s + 1) begin
            pm.attach(s[0]);
            pm.tick(4);
            chk(tap_sel, s[0]);
            chk(test_mode, 1'h1);
            for (i = 0; i < 4; i = i + 1) begin
                rnd = lfsr(rnd);
                inhibit <= rnd[3];
                tdo_b <= rnd[2];
                tdo_e <= !rnd[2];
                ten_b <= rnd[6];
                ten_e <= !rnd[6];
                pm.shift(rnd[0], rnd[1]);
                chk(pull_en, !rnd[3]);
                chk(s[0] ? e_tms : b_tms, rnd[0]);
                chk(s[0] ? e_tdi : b_tdi, rnd[1]);
                chk(s[0] ? b_tms : e_tms, 1'h1);
                chk(tdo_out, s[0] ^ rnd[2]);
                chk(tdo_oe, s[0] ^ rnd[6]);
                drv <= 0; lvl <= rnd[4]; pm.sel_en <= 1; pm.sel_v <= rnd[5];
                pm.tick(5);
                chk(evt_in, rnd[5]);
                drv <= 1; pm.sel_en <= 0;
                pm.tick(5);
                chk(sl_oe, 1'h1);
                chk(esl, rnd[4]);
                drv <= 0;
            end
            // one rise and one fall per shift, only on the chosen tap
            chk(n_br == 4 && n_bf == 4 && n_bt == 4, 1'h1);
            chk(n_er == 4 * s && n_ef == 4 * s && n_et == 4 * s, 1'h1);
            pm.tick(1);
            // frozen clock enable: the test reset drop must wait for it
            ce <= 0;
            pm.trst <= 0;
            pm.tick(8);
            chk(test_mode, 1'h1);
            ce <= 1;
            drv <= 1;
            pm.tick(8);
            chk(test_mode, 1'h0);
            chk(sl_oe, 1'h0);
            chk(tdo_oe, 1'h0);
            drv <= 0;
        end
        report_and_stop;
    end
endmodule
